// *** src/flash_ecc_pkg.sv ***
// Package of register indices, field layouts and reset values for the ECC fault capture block
package flash_ecc_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [7:0] IDX_RESULT_SELECT   = 8'h04;
  localparam logic [7:0] IDX_FAULT_FLAGS     = 8'h05;
  localparam logic [7:0] IDX_RESERVED_TEST_A = 8'h0C;
  localparam logic [7:0] IDX_RESERVED_TEST_B = 8'h0D;
  localparam logic [7:0] IDX_RESULT_HIGH     = 8'h0E;
  localparam logic [7:0] IDX_RESULT_LOW      = 8'h0F;
  localparam logic [7:0] IDX_OPTION          = 8'h10;
  localparam logic [7:0] IDX_RESERVED_TEST_C = 8'h11;
  localparam logic [7:0] IDX_RESERVED_TEST_D = 8'h12;
  localparam logic [7:0] IDX_RESERVED_TEST_E = 8'h13;

  // ==========================================================================
  // Result window selector codes
  // ==========================================================================
  localparam logic [2:0] SEL_PAR_ADDR_HI = 3'h0;
  localparam logic [2:0] SEL_ADDR_LO     = 3'h1;
  localparam logic [2:0] SEL_DATA0       = 3'h2;
  localparam logic [2:0] SEL_DATA1       = 3'h3;
  localparam logic [2:0] SEL_DATA2       = 3'h4;
  localparam logic [2:0] SEL_DATA3       = 3'h5;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int         FLAG_SINGLE_BIT  = 0;
  localparam int         FLAG_DOUBLE_BIT  = 1;
  localparam int         DFLASH_PAR_BITS  = 6;
  localparam logic [2:0] SELECT_RESET     = 3'h0;
  localparam logic [7:0] OPTION_RESET     = 8'hFF;
  localparam logic [7:0] OPTION_ALL_ONES  = 8'hFF;
  localparam logic [22:0] OPTION_FAULT_GLOBAL_ADDRESS    = 23'h7FFF0E;
  localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;

endpackage

// *** src/flash_ecc_fault_capture_regs.sv ***
// ECC fault capture, indexed result window and option byte behind an APB slave
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps

module flash_ecc_fault_capture_regs #(
  parameter int ADDR_W = 23,
  parameter int DATA_W = 64
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Array read path fault report
  input  wire logic              fault_single,
  input  wire logic              fault_double,
  input  wire logic              fault_is_pflash,
  input  wire logic [ADDR_W-1:0] fault_global_address,
  input  wire logic [7:0]        fault_parity,
  input  wire logic [DATA_W-1:0] fault_raw_data,
  // Reset-sequence option byte load
  input  wire logic              option_load,
  input  wire logic [7:0]        option_load_byte,
  input  wire logic              option_load_double,
  // Status towards the rest of the controller
  output logic                   single_flag,
  output logic                   double_flag,
  output logic [7:0]             option_bits
);

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  logic [9:0]  word_idx;
  logic        addr_aligned;
  logic        mapped;
  logic        setup_phase;
  logic        wr_access;

  assign word_idx     = paddr[11:2];
  assign addr_aligned = (paddr[1:0] == 2'h0);
  assign setup_phase  = psel && !penable;
  assign wr_access    = psel && penable && pwrite && !pslverr;
  assign pready       = 1'b1;

  always_comb begin
    mapped = 1'b0;
    if (addr_aligned && (word_idx[9:8] == 2'h0)) begin
      case (word_idx[7:0])
        flash_ecc_pkg::IDX_RESULT_SELECT,
        flash_ecc_pkg::IDX_FAULT_FLAGS,
        flash_ecc_pkg::IDX_RESERVED_TEST_A,
        flash_ecc_pkg::IDX_RESERVED_TEST_B,
        flash_ecc_pkg::IDX_RESULT_HIGH,
        flash_ecc_pkg::IDX_RESULT_LOW,
        flash_ecc_pkg::IDX_OPTION,
        flash_ecc_pkg::IDX_RESERVED_TEST_C,
        flash_ecc_pkg::IDX_RESERVED_TEST_D,
        flash_ecc_pkg::IDX_RESERVED_TEST_E: mapped = 1'b1;
        default:                             mapped = 1'b0;
      endcase
    end
  end

  // Error answer only in the access phase, one cycle, pready always high
  assign pslverr = psel && penable && !mapped;

  // ==========================================================================
  // Result select register
  // ==========================================================================
  logic [2:0] ecc_result_select_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecc_result_select_r <= flash_ecc_pkg::SELECT_RESET;
    end else if (wr_access && pstrb[0]
                 && word_idx[7:0] == flash_ecc_pkg::IDX_RESULT_SELECT) begin
      ecc_result_select_r <= pwdata[2:0];
    end
  end

  // ==========================================================================
  // Fault flags: hardware set wins over a same-cycle write-one clear
  // ==========================================================================
  logic [1:0] flags_r;
  logic [1:0] flag_clear;
  logic [1:0] flag_set;

  assign flag_clear = (wr_access && pstrb[0]
                       && word_idx[7:0] == flash_ecc_pkg::IDX_FAULT_FLAGS)
                      ? pwdata[1:0] : 2'h0;
  assign flag_set   = {fault_double, fault_single};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= 2'h0;
    end else begin
      flags_r <= (flags_r & ~flag_clear) | flag_set;
    end
  end

  assign single_flag = flags_r[flash_ecc_pkg::FLAG_SINGLE_BIT];
  assign double_flag = flags_r[flash_ecc_pkg::FLAG_DOUBLE_BIT];

  // ==========================================================================
  // Capture lock
  // ==========================================================================
  logic cap_locked_r;
  logic cap_kind_double_r;
  logic lock_release;
  logic capture;

  // Lock follows the flag of the captured kind, not just any flag
  assign lock_release = cap_kind_double_r
                        ? !flags_r[flash_ecc_pkg::FLAG_DOUBLE_BIT]
                        : !flags_r[flash_ecc_pkg::FLAG_SINGLE_BIT];
  assign capture      = (fault_single || fault_double) && !cap_locked_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_locked_r      <= 1'b0;
      cap_kind_double_r <= 1'b0;
    end else if (capture) begin
      cap_locked_r      <= 1'b1;
      cap_kind_double_r <= fault_double;
    end else if (cap_locked_r && lock_release) begin
      cap_locked_r      <= 1'b0;
    end
  end

  // ==========================================================================
  // Captured fields, latched together
  // ==========================================================================
  logic [7:0]        captured_parity_r;
  logic [ADDR_W-1:0] captured_addr_r;
  logic [DATA_W-1:0] captured_data_r;
  logic [7:0]        parity_in;
  logic [DATA_W-1:0] data_in;

  always_comb begin
    parity_in = fault_parity;
    data_in   = fault_raw_data;
    if (!fault_is_pflash) begin
      parity_in[7:flash_ecc_pkg::DFLASH_PAR_BITS] = 2'h0;
      data_in[DATA_W-1:16] = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      captured_parity_r <= 8'h00;
      captured_addr_r   <= '0;
      captured_data_r   <= '0;
    end else if (capture) begin
      captured_parity_r <= parity_in;
      captured_addr_r   <= fault_global_address;
      captured_data_r   <= data_in;
    end
  end

  // ==========================================================================
  // Result window mux
  // ==========================================================================
  logic [15:0] ecc_result_window;

  always_comb begin
    case (ecc_result_select_r)
      flash_ecc_pkg::SEL_PAR_ADDR_HI:
        ecc_result_window = {captured_parity_r, 1'b0, captured_addr_r[22:16]};
      flash_ecc_pkg::SEL_ADDR_LO: ecc_result_window = captured_addr_r[15:0];
      flash_ecc_pkg::SEL_DATA0:   ecc_result_window = captured_data_r[15:0];
      flash_ecc_pkg::SEL_DATA1:   ecc_result_window = captured_data_r[31:16];
      flash_ecc_pkg::SEL_DATA2:   ecc_result_window = captured_data_r[47:32];
      flash_ecc_pkg::SEL_DATA3:   ecc_result_window = captured_data_r[63:48];
      default:                    ecc_result_window = 16'h0000;
    endcase
  end

  // ==========================================================================
  // Option register
  // ==========================================================================
  logic [7:0] option_r;

  // Reset value is all ones so an unloaded part looks like an erased byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_r <= flash_ecc_pkg::OPTION_RESET;
    end else if (option_load) begin
      option_r <= option_load_double ? flash_ecc_pkg::OPTION_ALL_ONES
                                     : option_load_byte;
    end
  end

  assign option_bits = option_r;

  // ==========================================================================
  // Read data, captured in the setup phase
  // ==========================================================================
  logic [31:0] rdata_nxt;

  always_comb begin
    rdata_nxt = flash_ecc_pkg::RDATA_ZERO;
    case (word_idx[7:0])
      flash_ecc_pkg::IDX_RESULT_SELECT: rdata_nxt[2:0] = ecc_result_select_r;
      flash_ecc_pkg::IDX_FAULT_FLAGS:   rdata_nxt[1:0] = flags_r;
      flash_ecc_pkg::IDX_RESULT_HIGH:   rdata_nxt[7:0] = ecc_result_window[15:8];
      flash_ecc_pkg::IDX_RESULT_LOW:    rdata_nxt[7:0] = ecc_result_window[7:0];
      flash_ecc_pkg::IDX_OPTION:        rdata_nxt[7:0] = option_r;
      default:                          rdata_nxt = flash_ecc_pkg::RDATA_ZERO;
    endcase
    if (!mapped) begin
      rdata_nxt = flash_ecc_pkg::RDATA_ZERO;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= flash_ecc_pkg::RDATA_ZERO;
    end else if (setup_phase && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end

endmodule

// *** testbench/flash_ecc_fault_capture_regs_props.sv ***
// Port checks for the ECC fault capture block
`timescale 1ns/10ps
module flash_ecc_fault_capture_regs_props (
  // Clock and reset
  input wire logic        pclk, presetn,
  // APB
  input wire logic        psel, penable, pwrite, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  // Fault and option inputs
  input wire logic        fault_single, fault_double, option_load, option_load_double,
  input wire logic [7:0]  option_load_byte,
  // Status
  input wire logic        single_flag, double_flag,
  input wire logic [7:0]  option_bits
);
  logic rd_setup;
  logic flag_wr;
  assign rd_setup = psel && !penable && !pwrite;
  assign flag_wr = psel && penable && pwrite && paddr == 12'h014;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Assertions and cover points
  a_double_flag_set: assert property (fault_double |=> double_flag)
    else $error("double flag missing");
  a_single_flag_set: assert property (fault_single |=> single_flag)
    else $error("single flag missing");
  a_flag_only_cleared: assert property (
    $fell(double_flag) || $fell(single_flag) |-> $past(flag_wr))
    else $error("flag fell without a clear");
  a_option_load: assert property (
    option_load && !option_load_double |=> option_bits == $past(option_load_byte))
    else $error("option load wrong");
  a_option_double: assert property (
    option_load && option_load_double |=> option_bits == 8'hFF)
    else $error("option not all ones");
  a_option_hold: assert property (!option_load |=> $stable(option_bits))
    else $error("option changed");
  a_reserved_zero: assert property (
    rd_setup && paddr inside {12'h030, 12'h034, 12'h044, 12'h048, 12'h04C}
    |=> prdata == 32'h0) else $error("reserved read nonzero");
  a_option_read: assert property (
    rd_setup && paddr == 12'h040 |=> prdata == {24'h0, $past(option_bits)})
    else $error("option read wrong");
  a_window_no_err: assert property (
    psel && penable && paddr inside {12'h038, 12'h03C} |-> !pslverr)
    else $error("window access errored");
  c_both_faults: cover property (fault_single && fault_double);
  c_option_double: cover property (option_load && option_load_double);
  c_flag_clear: cover property (flag_wr ##1 !double_flag);
endmodule

bind flash_ecc_fault_capture_regs flash_ecc_fault_capture_regs_props props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pslverr(pslverr), .paddr(paddr), .prdata(prdata), .fault_single(fault_single),
  .fault_double(fault_double), .option_load(option_load), .option_load_double(option_load_double),
  .option_load_byte(option_load_byte), .single_flag(single_flag), .double_flag(double_flag),
  .option_bits(option_bits));

// *** testbench/flash_ecc_fault_capture_regs_tb.sv ***
// Directed testbench for the ECC fault capture register block
`timescale 1ns/10ps
module flash_ecc_fault_capture_regs_tb;
  // ==========================================================
  // Signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        fault_single, fault_double, fault_is_pflash;
  logic [22:0] fault_global_address;
  logic [7:0]  fault_parity, option_load_byte, option_bits;
  logic [63:0] fault_raw_data;
  logic        option_load, option_load_double, single_flag, double_flag;
  int          bad_count, cmp_count;

  flash_ecc_fault_capture_regs flash_ecc_fault_capture_regs_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .fault_single(fault_single), .fault_double(fault_double),
    .fault_is_pflash(fault_is_pflash), .fault_global_address(fault_global_address),
    .fault_parity(fault_parity), .fault_raw_data(fault_raw_data), .option_load(option_load),
    .option_load_byte(option_load_byte), .option_load_double(option_load_double),
    .single_flag(single_flag), .double_flag(double_flag), .option_bits(option_bits));

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  // ==========================================================
  // Tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic win(input logic [2:0] sel, input logic [15:0] exp);
    logic [15:0] got;
    apb(1'b1, flash_ecc_pkg::IDX_RESULT_SELECT, {29'h0, sel});
    apb(1'b0, flash_ecc_pkg::IDX_RESULT_HIGH, 32'h0);
    got[15:8] = rd[7:0];
    apb(1'b0, flash_ecc_pkg::IDX_RESULT_LOW, 32'h0);
    got[7:0] = rd[7:0];
    chk("window", {16'h0, got}, {16'h0, exp});
  endtask

  task automatic fault(input logic sg, input logic db, input logic pf, input logic [22:0] a,
                       input logic [7:0] p, input logic [63:0] d);
    @(posedge pclk);
    fault_single <= sg;
    fault_double <= db;
    fault_is_pflash <= pf;
    fault_global_address <= a;
    fault_parity <= p;
    fault_raw_data <= d;
    @(posedge pclk);
    fault_single <= 1'b0;
    fault_double <= 1'b0;
    // Let the flag update of the capture edge settle before anyone looks
    @(posedge pclk);
  endtask

  task automatic load_opt(input logic dbl);
    @(posedge pclk);
    option_load <= 1'b1;
    option_load_double <= dbl;
    @(posedge pclk);
    option_load <= 1'b0;
    apb(1'b1, flash_ecc_pkg::IDX_OPTION, 32'hA5);
    apb(1'b0, flash_ecc_pkg::IDX_OPTION, 32'h0);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    logic [7:0]  rsv [5];
    logic [15:0] pexp [8];
    rsv = '{8'h0C, 8'h0D, 8'h11, 8'h12, 8'h13};
    pexp = '{16'hC35A, 16'h1234, 16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h0000, 16'h0000};
    {psel, penable, pwrite, option_load, option_load_double} = '0;
    {fault_single, fault_double, fault_is_pflash, paddr, pwdata} = '0;
    {fault_global_address, fault_parity, fault_raw_data} = '0;
    pstrb = 4'hF;
    option_load_byte = 8'h5A;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk("option_reset", {24'h0, option_bits}, 32'hFF);
    foreach (rsv[i]) begin
      apb(1'b1, rsv[i], 32'hFF);
      apb(1'b0, rsv[i], 32'h0);
      chk("reserved", rd, 32'h0);
    end
    // Unmapped place: error response, no data
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    load_opt(1'b0);
    chk("option", rd, 32'h5A);
    load_opt(1'b1);
    chk("option_dbl", rd, 32'hFF);
    // Both faults at once, program flash
    fault(1'b1, 1'b1, 1'b1, 23'h5A_1234, 8'hC3, 64'h4444_3333_2222_1111);
    apb(1'b1, flash_ecc_pkg::IDX_RESULT_HIGH, 32'h55);
    for (int s = 0; s < 8; s++) win(s[2:0], pexp[s]);
    // Clearing only the single flag must not unlock a double capture
    apb(1'b1, flash_ecc_pkg::IDX_FAULT_FLAGS, 32'h1);
    fault(1'b1, 1'b0, 1'b0, 23'h00_0777, 8'hFF, 64'h0);
    chk("single_flag", {31'h0, single_flag}, 32'h1);
    win(3'h1, 16'h1234);
    apb(1'b1, flash_ecc_pkg::IDX_FAULT_FLAGS, 32'h2);
    apb(1'b1, flash_ecc_pkg::IDX_FAULT_FLAGS, 32'h1);
    chk("double_flag", {31'h0, double_flag}, 32'h0);
    // Data-flash capture after unlock
    fault(1'b1, 1'b0, 1'b0, 23'h12_ABCD, 8'hFF, 64'hAAAA_BBBB_CCCC_DDDD);
    win(3'h0, 16'h3F12);
    win(3'h1, 16'hABCD);
    win(3'h2, 16'hDDDD);
    win(3'h3, 16'h0000);
    end_sim();
  end

  // Generous bound: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    end_sim();
  end
endmodule
